// *** common/sacc_defines.svh ***
// constants for the successive-approximation conversion control block
`ifndef SACC_DEFINES_SVH
`define SACC_DEFINES_SVH

// ************************************************************
// conversion geometry
// ************************************************************
`define SACC_RES_BITS 12
`define SACC_CONV_CYCLES 4'hE
`define SACC_LAST_TRIAL 4'hC
`define SACC_CNT_RESET 4'h0
`define SACC_RESULT_RESET 12'h000

// ************************************************************
// timing
// ************************************************************
`define SACC_T_CONVERT_NS 1400
`define SACC_MCLK_PERIOD_NS 40
// longest time, rounded down to whole system clock cycles
`define SACC_CONVERT_CYC (`SACC_T_CONVERT_NS / `SACC_MCLK_PERIOD_NS)

`endif

// *** common/sacc_pkg.sv ***
// types shared by the conversion control block
package sacc_pkg;

   // ************************************************************
   // control states, gray along idle -> convert -> sleep and convert -> idle
   // ************************************************************
   typedef enum logic [1:0]
   {
      SACC_IDLE = 2'b00,
      SACC_CONV = 2'b01,
      SACC_SLEEP = 2'b11
   } sacc_state_t;

   // ************************************************************
   // status carried together toward the analog side and pins
   // ************************************************************
   typedef struct packed
   {
      logic busy;
      logic hold;
      logic sleep;
      logic power_up;
   } sacc_status_t;

endpackage : sacc_pkg

// *** rtl/sacc_sar_core.sv ***
// successive-approximation trial register driving the internal dac
`include "sacc_defines.svh"

module sacc_sar_core #(
   parameter int RES_BITS = `SACC_RES_BITS
)
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_load,
   input wire logic i_step,
   input wire logic [3:0] i_bit,
   input wire logic i_cmp,
   output logic [RES_BITS-1:0] o_trial
);

   logic [RES_BITS-1:0] trial_r;

   // ************************************************************
   // one bit decided per step, next lower bit set for trial
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         trial_r <= '0;
      end
      else if (i_load)
      begin
         // fresh trial per start, so no earlier sample leaks in
         trial_r <= '0;
         trial_r[RES_BITS-1] <= 1'b1;
      end
      else if (i_step)
      begin
         trial_r[i_bit] <= i_cmp;
         if (i_bit != 4'h0)
         begin
            trial_r[i_bit - 4'h1] <= 1'b1;
         end
      end
   end

   assign o_trial = trial_r;

endmodule : sacc_sar_core

// *** rtl/sacc_top.sv ***
// conversion control: start, busy, sleep, power and parallel read bus
`include "sacc_defines.svh"

module sacc_top #(
   parameter int RES_BITS = `SACC_RES_BITS
)
(
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   input wire logic I_CONVERSION_START_N,
   input wire logic I_CLKIN,
   input wire logic I_CMP,
   input wire logic I_AUTO_SHDN,
   input wire logic I_CS_N,
   input wire logic I_RD_N,
   output logic [RES_BITS-1:0] O_DAC,
   output logic O_HOLD,
   output logic O_BUSY,
   output logic O_SLEEP,
   output logic O_POWER_UP,
   output logic O_CLKIN_SLOW,
   output logic [RES_BITS-1:0] O_RESULT_BUS,
   output logic O_RESULT_BUS_OE_N
);

   // ************************************************************
   // declarations
   // ************************************************************
   sacc_pkg::sacc_state_t state_r;
   sacc_pkg::sacc_state_t state_nxt;
   sacc_pkg::sacc_status_t status_r;
   sacc_pkg::sacc_status_t status_nxt;
   logic start_q_r;
   logic clkin_q_r;
   logic start_fall;
   logic start_rise;
   logic clkin_rise;
   logic [3:0] cyc_r;
   logic [3:0] trial_bit;
   logic sar_load;
   logic sar_step;
   logic conv_done;
   logic [RES_BITS-1:0] trial;
   logic [RES_BITS-1:0] result_r;
   logic [7:0] watch_r;
   logic slow_r;

   localparam logic [7:0] CONVERT_CYC = 8'(`SACC_CONVERT_CYC);

   // ************************************************************
   // edge detection on the synchronous pins
   // ************************************************************

   // previous levels of start and master clock
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         start_q_r <= 1'b1;
         clkin_q_r <= 1'b0;
      end
      else
      begin
         start_q_r <= I_CONVERSION_START_N;
         clkin_q_r <= I_CLKIN;
      end
   end

   // start released high at reset, so a low strap gives a start as reset ends
   assign start_fall = start_q_r & ~I_CONVERSION_START_N;
   assign start_rise = ~start_q_r & I_CONVERSION_START_N;
   // master clock edges pace every conversion step
   assign clkin_rise = I_CLKIN & ~clkin_q_r;

   // ************************************************************
   // control state machine
   // ************************************************************

   // a start during busy is ignored; the host is expected to wait
   assign sar_load = start_fall && (state_r == sacc_pkg::SACC_IDLE);
   assign conv_done = (state_r == sacc_pkg::SACC_CONV) && clkin_rise &&
                      (cyc_r == `SACC_CONV_CYCLES - 4'h1);

   // next state
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         sacc_pkg::SACC_IDLE:
         begin
            if (sar_load)
            begin
               state_nxt = sacc_pkg::SACC_CONV;
            end
         end
         sacc_pkg::SACC_CONV:
         begin
            if (conv_done)
            begin
               // start still low at the end of conversion means sleep
               if (!I_CONVERSION_START_N)
               begin
                  state_nxt = sacc_pkg::SACC_SLEEP;
               end
               else
               begin
                  state_nxt = sacc_pkg::SACC_IDLE;
               end
            end
         end
         sacc_pkg::SACC_SLEEP:
         begin
            if (start_rise)
            begin
               state_nxt = sacc_pkg::SACC_IDLE;
            end
         end
         default:
         begin
            state_nxt = sacc_pkg::SACC_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         state_r <= sacc_pkg::SACC_IDLE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // ************************************************************
   // status outputs, registered alongside the state
   // ************************************************************

   // busy and hold share one edge with the state change
   always_comb
   begin
      status_nxt.busy = (state_nxt == sacc_pkg::SACC_CONV);
      // hold drops with busy, so tracking restarts as busy falls
      status_nxt.hold = (state_nxt == sacc_pkg::SACC_CONV);
      status_nxt.sleep = (state_nxt == sacc_pkg::SACC_SLEEP);
      // auto mode powers only the converting interval
      if (I_AUTO_SHDN)
      begin
         status_nxt.power_up = (state_nxt == sacc_pkg::SACC_CONV);
      end
      else
      begin
         status_nxt.power_up = (state_nxt != sacc_pkg::SACC_SLEEP);
      end
   end

   // status register
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         status_r <= '0;
      end
      else
      begin
         status_r <= status_nxt;
      end
   end

   assign O_BUSY = status_r.busy;
   assign O_HOLD = status_r.hold;
   assign O_SLEEP = status_r.sleep;
   assign O_POWER_UP = status_r.power_up;

   // ************************************************************
   // master clock cycle counter
   // ************************************************************

   // counts master clock rises since the start strobe
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         cyc_r <= `SACC_CNT_RESET;
      end
      else if (sar_load)
      begin
         cyc_r <= `SACC_CNT_RESET;
      end
      else if ((state_r == sacc_pkg::SACC_CONV) && clkin_rise)
      begin
         cyc_r <= cyc_r + 4'h1;
      end
   end

   // rises 1 to 12 decide bits 11 down to 0; 13 settles, 14 stores
   assign sar_step = (state_r == sacc_pkg::SACC_CONV) && clkin_rise &&
                     (cyc_r < `SACC_LAST_TRIAL);
   assign trial_bit = `SACC_LAST_TRIAL - 4'h1 - cyc_r;

   // ************************************************************
   // successive-approximation register
   // ************************************************************
   sacc_sar_core #(
      .RES_BITS(RES_BITS)
   )
   u_sar (
      .i_clk(I_MCLK),
      .i_rst_b(I_RST_B),
      .i_load(sar_load),
      .i_step(sar_step),
      .i_bit(trial_bit),
      .i_cmp(I_CMP),
      .o_trial(trial)
   );

   assign O_DAC = trial;

   // ************************************************************
   // output register and parallel read bus
   // ************************************************************

   // result of this conversion stored on the edge busy falls
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         result_r <= `SACC_RESULT_RESET;
      end
      else if (conv_done)
      begin
         result_r <= trial;
      end
   end

   // either strobe gates the bus; both tied low keeps it always driven
   assign O_RESULT_BUS = result_r;
   assign O_RESULT_BUS_OE_N = I_CS_N | I_RD_N;

   // ************************************************************
   // conversion length watch
   // ************************************************************

   // counts system cycles of the running conversion
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         watch_r <= 8'h00;
      end
      else if (sar_load)
      begin
         watch_r <= 8'h00;
      end
      else if ((state_r == sacc_pkg::SACC_CONV) && (watch_r != CONVERT_CYC))
      begin
         watch_r <= watch_r + 8'h01;
      end
   end

   // busy is only bounded by 1.4 us while the master clock is in range;
   // flag it rather than cut the conversion short
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         slow_r <= 1'b0;
      end
      else if ((state_r == sacc_pkg::SACC_CONV) && (watch_r == CONVERT_CYC))
      begin
         slow_r <= 1'b1;
      end
      else if (sar_load)
      begin
         slow_r <= 1'b0;
      end
   end

   assign O_CLKIN_SLOW = slow_r;

endmodule : sacc_top

// *** verif/sacc_far.sv ***
// partner model: master clock source and comparator
module sacc_far
(
   input wire logic i_clk,
   input wire logic i_busy,
   input wire logic i_fast,
   input wire logic [11:0] i_vin,
   input wire logic [11:0] i_dac,
   output logic o_clkin,
   output logic o_cmp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_r;
   // phase runs only in a frame; fast is the in-range clock the bench asks for
   always_ff @(posedge i_clk)
   begin
      if (!i_busy)
         ph_r <= 2'h0;
      else
         ph_r <= (ph_r == (i_fast ? 2'h1 : 2'h2)) ? 2'h0 : ph_r + 2'h1;
   end
   // still low between frames, 8.3 MHz otherwise, or 12.5 MHz when fast
   assign o_clkin = i_busy && ph_r == 2'h1;
   assign o_cmp = i_vin >= i_dac;
endmodule : sacc_far

// *** verif/sacc_chk.sv ***
// assertion checker for the conversion control top
module sacc_chk #(parameter int RES_BITS = 12)
(
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   input wire logic I_CONVERSION_START_N,
   input wire logic I_CLKIN,
   input wire logic I_CMP,
   input wire logic I_AUTO_SHDN,
   input wire logic I_CS_N,
   input wire logic I_RD_N,
   input wire logic [RES_BITS-1:0] O_DAC,
   input wire logic O_HOLD,
   input wire logic O_BUSY,
   input wire logic O_SLEEP,
   input wire logic O_POWER_UP,
   input wire logic O_CLKIN_SLOW,
   input wire logic [RES_BITS-1:0] O_RESULT_BUS,
   input wire logic O_RESULT_BUS_OE_N
);
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_q_r;
   logic [3:0] rise_cnt_r;
   // count master clock rises inside one conversion
   always_ff @(posedge I_MCLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         clk_q_r <= 1'b0;
         rise_cnt_r <= 4'h0;
      end
      else
      begin
         clk_q_r <= I_CLKIN;
         rise_cnt_r <= !O_BUSY ? 4'h0 : rise_cnt_r + 4'(I_CLKIN & ~clk_q_r);
      end
   end
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_B);
   property p_oe; O_RESULT_BUS_OE_N == (I_CS_N | I_RD_N); endproperty
   property p_hold; O_HOLD == O_BUSY; endproperty
   property p_start;
      $fell(I_CONVERSION_START_N) && !O_BUSY && !O_SLEEP |=> O_BUSY && O_DAC == 12'h800;
   endproperty
   property p_len; $fell(O_BUSY) |-> rise_cnt_r == 4'hE; endproperty
   property p_max; O_BUSY |-> rise_cnt_r < 4'hE; endproperty
   property p_keep; !$stable(O_RESULT_BUS) |-> $fell(O_BUSY); endproperty
   property p_sleep; $fell(O_BUSY) |-> O_SLEEP == !$past(I_CONVERSION_START_N); endproperty
   property p_wake; O_SLEEP && $rose(I_CONVERSION_START_N) |=> !O_SLEEP; endproperty
   property p_auto; $past(I_AUTO_SHDN) && !O_BUSY |-> !O_POWER_UP; endproperty
   property p_pwr; O_BUSY |-> O_POWER_UP; endproperty
   property p_off; O_SLEEP |-> !O_POWER_UP && !O_BUSY; endproperty
   a_oe: assert property (p_oe) else $error("bus enable wrong");
   a_hold: assert property (p_hold) else $error("hold differs from busy");
   a_start: assert property (p_start) else $error("start not taken");
   a_len: assert property (p_len) else $error("busy length wrong");
   a_max: assert property (p_max) else $error("busy too long");
   a_keep: assert property (p_keep) else $error("result moved");
   a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
   a_wake: assert property (p_wake) else $error("no wake");
   a_auto: assert property (p_auto) else $error("auto power on");
   a_pwr: assert property (p_pwr) else $error("power off in conversion");
   a_off: assert property (p_off) else $error("sleep with power");
   c_done: cover property ($fell(O_BUSY));
   c_sleep: cover property ($rose(O_SLEEP));
   c_read: cover property (!O_RESULT_BUS_OE_N && !O_BUSY);
endmodule : sacc_chk
bind sacc_top sacc_chk #(.RES_BITS(RES_BITS)) u_chk (.I_MCLK, .I_RST_B, .I_CONVERSION_START_N,
   .I_CLKIN, .I_CMP, .I_AUTO_SHDN, .I_CS_N, .I_RD_N, .O_DAC, .O_HOLD, .O_BUSY, .O_SLEEP,
   .O_POWER_UP, .O_CLKIN_SLOW, .O_RESULT_BUS, .O_RESULT_BUS_OE_N);

// *** verif/sacc_top_tb.sv ***
// self-checking bench for the conversion control top
module sacc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst_b = 1'b0, start_n = 1'b1, auto_shdn = 1'b0;
   logic cs_n = 1'b1, rd_n = 1'b1, fast = 1'b0, clkin, cmp;
   logic hold, busy, sleep, pwr, slow, oe_n;
   logic [11:0] vin = 12'h000, dac, bus;
   logic [11:0] corner [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'h001};
   int num_errors = 0, checked = 0, seed = 79, r;
   always #20 mclk = ~mclk;
   sacc_top DUT (.I_MCLK(mclk), .I_RST_B(rst_b), .I_CONVERSION_START_N(start_n), .I_CLKIN(clkin),
      .I_CMP(cmp), .I_AUTO_SHDN(auto_shdn), .I_CS_N(cs_n), .I_RD_N(rd_n), .O_DAC(dac), .O_HOLD(hold),
      .O_BUSY(busy), .O_SLEEP(sleep), .O_POWER_UP(pwr), .O_CLKIN_SLOW(slow), .O_RESULT_BUS(bus),
      .O_RESULT_BUS_OE_N(oe_n));
   sacc_far u_far (.i_clk(mclk), .i_busy(busy), .i_fast(fast), .i_vin(vin), .i_dac(dac),
      .o_clkin(clkin), .o_cmp(cmp));
   task chk_bit(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit
   task chk_word(input string name, input logic [11:0] exp, input logic [11:0] got);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_word
   // power stays up after a frame only in normal mode and awake
   function logic exp_pwr(input logic a, input logic h);
      return !a && !h;
   endfunction : exp_pwr
   task test_done;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   // ************
   // one conversion, a refused restart unless sleeping, a gated read
   // ************
   task convert(input logic [11:0] v, input logic a, input logic f, input logic h);
      int n;
      n = 0;
      @(posedge mclk);
      vin <= v;
      auto_shdn <= a;
      fast <= f;
      start_n <= 1'b0;
      repeat (3) @(posedge mclk);
      start_n <= !h; // start kept low through the frame asks for sleep
      if (!h)
      begin
         repeat (4) @(posedge mclk);
         start_n <= 1'b0; // restart while busy must be ignored
         @(posedge mclk);
         start_n <= 1'b1;
      end
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (busy !== 1'b0 && n < 200);
      chk_bit("busy", 1'b0, busy);
      chk_bit("sleep", h, sleep);
      chk_bit("power", exp_pwr(a, h), pwr);
      chk_bit("slow", !f, slow);
      @(posedge mclk);
      cs_n <= 1'b0;
      @(negedge mclk);
      chk_bit("oe_n", 1'b1, oe_n);
      @(posedge mclk);
      rd_n <= 1'b0;
      @(negedge mclk);
      chk_bit("oe_n", 1'b0, oe_n);
      chk_word("result", v, bus);
      @(posedge mclk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      if (h)
      begin
         @(posedge mclk);
         start_n <= 1'b1;
         repeat (2) @(negedge mclk);
         chk_bit("sleep", 1'b0, sleep);
      end
   endtask : convert
   // ************
   // corners first, then seeded random frames
   // ************
   initial
   begin
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         convert(corner[i], i[0], i[1], i == 4);
         $display("test %0d done", i);
      end
      // mid-run reset: slow flag, status and stored result all clear
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(negedge mclk);
      chk_bit("slow", 1'b0, slow);
      chk_bit("busy", 1'b0, busy);
      chk_bit("power", 1'b0, pwr);
      chk_word("result", 12'h000, bus);
      @(posedge mclk);
      rst_b <= 1'b1;
      $display("test reset done");
      for (int i = 5; i < 20; i++)
      begin
         r = $random(seed);
         convert(r[11:0], r[12], r[13], r[14]);
         $display("test %0d done", i);
      end
      test_done();
   end
   // twenty frames of at most 250 cycles, doubled for margin
   initial
   begin
      repeat (10000) @(posedge mclk);
      num_errors++;
      test_done();
   end
endmodule : sacc_top_tb
